// ### design/param_store_pkg.sv
package param_store_pkg;

    // Command codes.
    localparam logic [7:0] CMD_AXIS_RESTORE = 8'h08;
    localparam logic [7:0] CMD_GLOBAL_WRITE = 8'h09;
    localparam logic [7:0] CMD_GLOBAL_READ = 8'h0a;
    localparam logic [7:0] CMD_GLOBAL_STORE = 8'h0b;
    localparam logic [7:0] CMD_GLOBAL_RESTORE = 8'h0c;

    // Banks.
    localparam logic [7:0] BANK_SETTINGS = 8'h00;
    localparam logic [7:0] BANK_USER = 8'h02;
    localparam logic [7:0] BANK_IRQ = 8'h03;

    // Reply status codes.
    localparam logic [7:0] STATUS_OK = 8'h64;
    localparam logic [7:0] STATUS_BAD_CHECKSUM = 8'h01;
    localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
    localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;

    // Array geometry and frame layout.
    localparam int PARAM_ENTRIES = 256;
    localparam logic [3:0] FRAME_LAST = 4'h8;
    localparam logic [7:0] INIT_LAST = 8'hff;

    // Reset values.
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Nonvolatile space: bank select in the upper address bits.
    localparam logic [1:0] NV_AXIS = 2'h0;
    localparam logic [1:0] NV_SETTINGS = 2'h1;
    localparam logic [1:0] NV_USER = 2'h2;

endpackage

// ### design/param_store_cmd.sv
`timescale 1ns/1ps

// Behaviour
// - Code 8 reloads one axis parameter from storage
// - Power-up loads all axis parameters first
// - Code 9 writes value into banked global
// - Bank 0 writes also commit to storage
// - Code 10 copies global into accumulator
// - Read reply is status 100 with value
// - Code 11 bank 2 stores user variable
// - Power-up and code 12 reload user variables
module param_store_cmd
    import param_store_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_NRST,
    input wire logic I_RX_VALID,
    input wire logic [7:0] I_RX_BYTE,
    input wire logic I_NV_DONE,
    input wire logic [31:0] I_NV_RDATA,
    output logic O_NV_REQ,
    output logic O_NV_WRITE,
    output logic [9:0] O_NV_ADDR,
    output logic [31:0] O_NV_WDATA,
    output logic O_REPLY_VALID,
    output logic [7:0] O_REPLY_STATUS,
    output logic [31:0] O_REPLY_VALUE,
    output logic O_READY,
    output logic [31:0] O_ACCU
);

    typedef enum logic [5:0] {
        ST_INIT = 6'b000001,
        ST_IDLE = 6'b000010,
        ST_EXEC = 6'b000100,
        ST_NV_REQ = 6'b001000,
        ST_NV_WAIT = 6'b010000,
        ST_REPLY = 6'b100000
    } state_e;

    ////////////////////////////////////////////////////////////////////////////
    // Storage arrays for the working copies.
    logic [31:0] axis_mem [PARAM_ENTRIES];
    logic [31:0] set_mem [PARAM_ENTRIES];
    logic [31:0] user_mem [PARAM_ENTRIES];
    logic [31:0] irq_mem [PARAM_ENTRIES];

    state_e state_r;
    logic [3:0] idx_r;
    logic [7:0] sum_r;
    logic [7:0] cmd_r;
    logic [7:0] type_r;
    logic [7:0] bank_r;
    logic [31:0] value_r;
    logic [7:0] status_r;
    logic init_user_r;
    logic [7:0] init_idx_r;
    logic nv_write_r;
    logic [9:0] nv_addr_r;
    logic [31:0] nv_wdata_r;
    logic [31:0] accu_r;
    logic [31:0] reply_value_r;
    logic frame_done;
    logic sum_ok;
    logic read_hit;

    // Byte-wise sum, used for the running checksum that the final byte is compared against.
    function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
        add8 = 8'(a + b);
    endfunction

    function automatic logic [9:0] nv_addr(input logic [1:0] sel, input logic [7:0] idx);
        nv_addr = {sel, idx};
    endfunction

    // Reply status of a frame whose checksum matched; each command has its own legal banks.
    function automatic logic [7:0] cmd_status(input logic [7:0] cmd, input logic [7:0] bank);
        case (cmd)
            CMD_AXIS_RESTORE: cmd_status = (bank == BANK_SETTINGS) ? STATUS_OK : STATUS_BAD_TYPE;
            CMD_GLOBAL_WRITE, CMD_GLOBAL_READ:
                cmd_status = (bank == BANK_SETTINGS || bank == BANK_USER || bank == BANK_IRQ) ?
                    STATUS_OK : STATUS_BAD_TYPE;
            CMD_GLOBAL_STORE, CMD_GLOBAL_RESTORE: cmd_status = (bank == BANK_USER) ? STATUS_OK : STATUS_BAD_TYPE;
            default: cmd_status = STATUS_BAD_CMD;
        endcase
    endfunction

    // Commands that need one storage transfer before their reply.
    function automatic logic nv_cmd(input logic [7:0] cmd, input logic [7:0] bank);
        nv_cmd = ((cmd == CMD_AXIS_RESTORE || cmd == CMD_GLOBAL_WRITE) && bank == BANK_SETTINGS) ||
            ((cmd == CMD_GLOBAL_STORE || cmd == CMD_GLOBAL_RESTORE) && bank == BANK_USER);
    endfunction

    // Banked global read, shared by the accumulator and the reply value.
    function automatic logic [31:0] global_rd(input logic [7:0] bank, input logic [7:0] idx);
        case (bank)
            BANK_SETTINGS: global_rd = set_mem[idx];
            BANK_USER: global_rd = user_mem[idx];
            default: global_rd = irq_mem[idx];
        endcase
    endfunction

    assign frame_done = (state_r == ST_IDLE) && I_RX_VALID && (idx_r == FRAME_LAST);
    assign sum_ok = (sum_r == I_RX_BYTE);
    assign read_hit = (state_r == ST_EXEC) && (cmd_r == CMD_GLOBAL_READ) && (cmd_status(cmd_r, bank_r) == STATUS_OK);

    ////////////////////////////////////////////////////////////////////////////
    // Frame capture; bytes arriving while busy are dropped without moving the byte index,
    // so the next bytes taken in IDLE continue the frame at the kept position.
    always_ff @(posedge I_SYS_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            idx_r <= 4'h0;
            sum_r <= BYTE_RESET;
            cmd_r <= BYTE_RESET;
            type_r <= BYTE_RESET;
            bank_r <= BYTE_RESET;
            value_r <= WORD_RESET;
        end
        else if (state_r == ST_IDLE && I_RX_VALID)
        begin
            case (idx_r)
                4'h1: cmd_r <= I_RX_BYTE;
                4'h2: type_r <= I_RX_BYTE;
                4'h3: bank_r <= I_RX_BYTE;
                4'h4, 4'h5, 4'h6, 4'h7: value_r <= {value_r[23:0], I_RX_BYTE};
                default: ;
            endcase
            sum_r <= (idx_r == FRAME_LAST) ? BYTE_RESET : add8(sum_r, I_RX_BYTE);
            idx_r <= (idx_r == FRAME_LAST) ? 4'h0 : 4'(idx_r + 4'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: power-up load, then command execution.
    always_ff @(posedge I_SYS_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            state_r <= ST_INIT;
            init_user_r <= 1'b0;
            init_idx_r <= BYTE_RESET;
            status_r <= BYTE_RESET;
            nv_write_r <= 1'b0;
            nv_addr_r <= 10'h000;
            nv_wdata_r <= WORD_RESET;
        end
        else
        begin
            case (state_r)
                ST_INIT:
                begin
                    nv_write_r <= 1'b0;
                    nv_addr_r <= nv_addr(init_user_r ? NV_USER : NV_AXIS, init_idx_r);
                    state_r <= ST_NV_REQ;
                end
                ST_IDLE:
                begin
                    if (frame_done)
                    begin
                        status_r <= sum_ok ? STATUS_OK : STATUS_BAD_CHECKSUM;
                        state_r <= sum_ok ? ST_EXEC : ST_REPLY;
                    end
                end
                ST_EXEC:
                begin
                    status_r <= cmd_status(cmd_r, bank_r);
                    state_r <= nv_cmd(cmd_r, bank_r) ? ST_NV_REQ : ST_REPLY;
                    if (nv_cmd(cmd_r, bank_r))
                    begin
                        nv_write_r <= (cmd_r == CMD_GLOBAL_WRITE) || (cmd_r == CMD_GLOBAL_STORE);
                        nv_addr_r <= nv_addr((cmd_r == CMD_AXIS_RESTORE) ? NV_AXIS :
                            ((cmd_r == CMD_GLOBAL_WRITE) ? NV_SETTINGS : NV_USER), type_r);
                        nv_wdata_r <= (cmd_r == CMD_GLOBAL_STORE) ? user_mem[type_r] : value_r;
                    end
                end
                ST_NV_REQ: state_r <= ST_NV_WAIT;
                ST_NV_WAIT:
                begin
                    if (I_NV_DONE && O_READY)
                        state_r <= ST_REPLY;
                    else if (I_NV_DONE)
                    begin
                        // Power-up user load follows axis load
                        init_user_r <= init_user_r || (init_idx_r == INIT_LAST);
                        init_idx_r <= 8'(init_idx_r + 8'h01);
                        state_r <= (init_user_r && init_idx_r == INIT_LAST) ? ST_IDLE : ST_INIT;
                    end
                end
                ST_REPLY: state_r <= ST_IDLE;
                default: state_r <= ST_INIT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ready marks the end of the power-up load; it never drops again.
    always_ff @(posedge I_SYS_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
            O_READY <= 1'b0;
        else if (state_r == ST_NV_WAIT && I_NV_DONE && init_user_r && init_idx_r == INIT_LAST)
            O_READY <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Working copy updates; arrays have no reset, the power-up load fills axis_mem and user_mem only.
    always_ff @(posedge I_SYS_CLK)
    begin
        if (state_r == ST_NV_WAIT && I_NV_DONE && !nv_write_r)
        begin
            if (nv_addr_r[9:8] == NV_AXIS)
                axis_mem[nv_addr_r[7:0]] <= I_NV_RDATA;
            if (nv_addr_r[9:8] == NV_USER)
                user_mem[nv_addr_r[7:0]] <= I_NV_RDATA;
        end
        if (state_r == ST_EXEC && cmd_r == CMD_GLOBAL_WRITE)
        begin
            case (bank_r)
                BANK_SETTINGS: set_mem[type_r] <= value_r;
                BANK_USER: user_mem[type_r] <= value_r;
                BANK_IRQ: irq_mem[type_r] <= value_r;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Accumulator and reply value; the value is cleared for every other frame, a bad one included,
    // so a stale read never rides on a later reply.
    always_ff @(posedge I_SYS_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            accu_r <= WORD_RESET;
            reply_value_r <= WORD_RESET;
        end
        else if (read_hit)
        begin
            accu_r <= global_rd(bank_r, type_r);
            reply_value_r <= global_rd(bank_r, type_r);
        end
        else if (frame_done || state_r == ST_EXEC)
            reply_value_r <= WORD_RESET;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs.
    always_ff @(posedge I_SYS_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            O_NV_REQ <= 1'b0;
            O_NV_WRITE <= 1'b0;
            O_NV_ADDR <= 10'h000;
            O_NV_WDATA <= WORD_RESET;
            O_REPLY_VALID <= 1'b0;
            O_REPLY_STATUS <= BYTE_RESET;
            O_REPLY_VALUE <= WORD_RESET;
            O_ACCU <= WORD_RESET;
        end
        else
        begin
            O_NV_REQ <= (state_r == ST_NV_REQ);
            O_NV_WRITE <= nv_write_r;
            O_NV_ADDR <= nv_addr_r;
            O_NV_WDATA <= nv_wdata_r;
            O_REPLY_VALID <= (state_r == ST_REPLY);
            O_REPLY_STATUS <= status_r;
            O_REPLY_VALUE <= reply_value_r;
            O_ACCU <= accu_r;
        end
    end

endmodule // param_store_cmd

// ### tb/param_store_nv_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Storage seen by the handler: one word per request, answered after i_dly+1 edges.
module param_store_nv_model
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [9:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_dly,
    output logic o_done,
    output logic [31:0] o_rdata
);
    logic [31:0] mem [0:1023];
    logic [9:0] addr_r;
    logic wr_r;
    logic [31:0] wd_r;
    int wait_r;
    int n_rd;
    int n_wr;

    // Every word starts as a pattern that carries its own address.
    initial
    begin
        for (int i = 0; i < 1024; i++)
            mem[i] = 32'ha500_0000 + 32'(i);
    end

    // Read data is only meaningful with o_done; otherwise it toggles so a late sample shows up.
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wait_r <= 0;
            o_done <= 1'b0;
            o_rdata <= 32'h0;
            n_rd <= 0;
            n_wr <= 0;
        end
        else
        begin
            o_done <= 1'b0;
            o_rdata <= ~o_rdata;
            if (i_req)
            begin
                addr_r <= i_addr;
                wr_r <= i_write;
                wd_r <= i_wdata;
                wait_r <= 32'(i_dly) + 1;
            end
            else if (wait_r > 0)
            begin
                wait_r <= wait_r - 1;
                if (wait_r == 1)
                begin
                    o_done <= 1'b1;
                    if (wr_r)
                    begin
                        mem[addr_r] <= wd_r;
                        n_wr <= n_wr + 1;
                    end
                    else
                    begin
                        o_rdata <= mem[addr_r];
                        n_rd <= n_rd + 1;
                    end
                end
            end
        end
    end
endmodule // param_store_nv_model

// ### tb/param_store_cmd_checker.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Timing relations between frames, storage traffic and replies.
module param_store_cmd_checker
    import param_store_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_NRST,
    input wire logic I_RX_VALID,
    input wire logic I_NV_DONE,
    input wire logic O_NV_REQ,
    input wire logic O_NV_WRITE,
    input wire logic [9:0] O_NV_ADDR,
    input wire logic O_REPLY_VALID,
    input wire logic [7:0] O_REPLY_STATUS,
    input wire logic [31:0] O_REPLY_VALUE,
    input wire logic O_READY,
    input wire logic [31:0] O_ACCU
);
    logic pend_r;

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_NRST);

    // Tracks the one storage request allowed in flight.
    always_ff @(posedge I_SYS_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
            pend_r <= 1'b0;
        else if (O_NV_REQ)
            pend_r <= 1'b1;
        else if (I_NV_DONE)
            pend_r <= 1'b0;
    end

    property p_one_req; O_NV_REQ |-> !pend_r; endproperty
    a_one_req: assert property (p_one_req) else $error("second storage request in flight");
    property p_ready_hold; O_READY |=> O_READY; endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
    property p_ready_cause; $rose(O_READY) |-> $past(I_NV_DONE) || $past(I_NV_DONE, 2); endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without load end");
    property p_no_early_reply; O_REPLY_VALID |-> O_READY; endproperty
    a_no_early_reply: assert property (p_no_early_reply) else $error("reply before load");
    // A bad checksum answers one cycle sooner than an executed command.
    property p_reply_cause;
        O_REPLY_VALID |-> $past(I_RX_VALID, 2) || $past(I_RX_VALID, 3) || $past(I_NV_DONE, 2);
    endproperty
    a_reply_cause: assert property (p_reply_cause) else $error("reply without cause");
    property p_read_accu; O_REPLY_VALID && O_REPLY_VALUE != 32'h0 |-> O_REPLY_VALUE == O_ACCU; endproperty
    a_read_accu: assert property (p_read_accu) else $error("reply value differs from accu");
    property p_write_area; O_NV_REQ && O_NV_WRITE |-> O_NV_ADDR[9:8] != NV_AXIS; endproperty
    a_write_area: assert property (p_write_area) else $error("axis area written");
    property p_nv_reply; O_NV_REQ && O_READY |=> !O_REPLY_VALID ##[1:20] O_REPLY_VALID; endproperty
    a_nv_reply: assert property (p_nv_reply) else $error("storage command not answered");
    property p_reply_pulse; O_REPLY_VALID |=> !O_REPLY_VALID; endproperty
    a_reply_pulse: assert property (p_reply_pulse) else $error("reply longer than a cycle");
endmodule // param_store_cmd_checker

bind param_store_cmd param_store_cmd_checker u_chk (.I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST),
    .I_RX_VALID(I_RX_VALID), .I_NV_DONE(I_NV_DONE), .O_NV_REQ(O_NV_REQ), .O_NV_WRITE(O_NV_WRITE),
    .O_NV_ADDR(O_NV_ADDR), .O_REPLY_VALID(O_REPLY_VALID), .O_REPLY_STATUS(O_REPLY_STATUS),
    .O_REPLY_VALUE(O_REPLY_VALUE), .O_READY(O_READY), .O_ACCU(O_ACCU));

// ### tb/param_store_cmd_tb.sv
`timescale 1ns/1ps

module param_store_cmd_tb;
    import param_store_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic rx_valid = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic [3:0] dly = 4'h0;
    logic nv_req, nv_wr, nv_done, rep_valid, ready;
    logic [9:0] nv_addr;
    logic [31:0] nv_wdata, nv_rdata, rep_value, accu, vl;
    logic [7:0] rep_status, st;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;

    always #2.5 clk = ~clk;

    param_store_cmd dut (.I_SYS_CLK(clk), .I_NRST(nrst), .I_RX_VALID(rx_valid), .I_RX_BYTE(rx_byte),
        .I_NV_DONE(nv_done), .I_NV_RDATA(nv_rdata), .O_NV_REQ(nv_req), .O_NV_WRITE(nv_wr),
        .O_NV_ADDR(nv_addr), .O_NV_WDATA(nv_wdata), .O_REPLY_VALID(rep_valid),
        .O_REPLY_STATUS(rep_status), .O_REPLY_VALUE(rep_value), .O_READY(ready), .O_ACCU(accu));
    param_store_nv_model nv (.i_clk(clk), .i_nrst(nrst), .i_req(nv_req), .i_write(nv_wr),
        .i_addr(nv_addr), .i_wdata(nv_wdata), .i_dly(dly), .o_done(nv_done), .o_rdata(nv_rdata));

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and close.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Sends one frame, waits for its reply; bad flips checksum bits.
    task automatic send(input logic [7:0] cmd, typ, bnk, input logic [31:0] val, input logic [7:0] bad);
        logic [7:0] b [9];
        logic got;
        b = '{8'h01, cmd, typ, bnk, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
        for (int i = 0; i < 8; i++)
            b[8] += b[i];
        b[8] ^= bad;
        for (int i = 0; i < 9; i++)
        begin
            rx_valid = 1'b1;
            rx_byte = b[i];
            @(posedge clk);
            #1;
        end
        rx_valid = 1'b0;
        rx_byte = ~rx_byte;
        got = 1'b0;
        // Replies stand one cycle, so each cycle is looked at once it settles.
        for (int i = 0; i < 80 && !got; i++)
        begin
            @(posedge clk);
            #1;
            got = (rep_valid === 1'b1);
            st = rep_status;
            vl = rep_value;
        end
        chk("reply seen", 32'(got), 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_boot();
        for (int i = 0; i < 4000 && ready !== 1'b1; i++)
            @(posedge clk);
        #1;
        chk("ready", 32'(ready), 32'h1);
        chk("boot reads", nv.n_rd, 512);
        send(CMD_GLOBAL_READ, 8'h05, BANK_USER, 32'hffff_ffff, 8'h00);
        chk("boot user", vl, 32'ha500_0205);
        chk("read status", 32'(st), 32'(STATUS_OK));
        chk("accu", accu, 32'ha500_0205);
        $display("test boot done");
    endtask

    task automatic t_write();
        int w;
        w = nv.n_wr;
        send(CMD_GLOBAL_WRITE, 8'h07, BANK_USER, 32'h1234_5678, 8'h00);
        send(CMD_GLOBAL_WRITE, 8'h07, BANK_IRQ, 32'h8765_4321, 8'h00);
        chk("no commit", nv.n_wr - w, 0);
        send(CMD_GLOBAL_READ, 8'h07, BANK_USER, 32'h0, 8'h00);
        chk("user var", vl, 32'h1234_5678);
        send(CMD_GLOBAL_READ, 8'h07, BANK_IRQ, 32'h0, 8'h00);
        chk("irq var", vl, 32'h8765_4321);
        dly = 4'h6;
        send(CMD_GLOBAL_WRITE, 8'h42, BANK_SETTINGS, 32'h3, 8'h00);
        chk("bank0 commit", nv.mem[10'h142], 32'h3);
        send(CMD_GLOBAL_READ, 8'h42, BANK_SETTINGS, 32'h0, 8'h00);
        chk("bank0 read", vl, 32'h3);
        send(CMD_GLOBAL_WRITE, 8'h07, BANK_USER, 32'h0, 8'h01);
        chk("bad sum", 32'(st), 32'(STATUS_BAD_CHECKSUM));
        send(CMD_GLOBAL_READ, 8'h07, BANK_USER, 32'h0, 8'h00);
        chk("kept", vl, 32'h1234_5678);
        $display("test write done");
    endtask

    task automatic t_store();
        int r;
        send(CMD_GLOBAL_WRITE, 8'h2a, BANK_USER, 32'hcafe_0001, 8'h00);
        send(CMD_GLOBAL_STORE, 8'h2a, BANK_USER, 32'h0, 8'h00);
        chk("store status", 32'(st), 32'(STATUS_OK));
        chk("store value", vl, 32'h0);
        chk("stored", nv.mem[10'h22a], 32'hcafe_0001);
        send(CMD_GLOBAL_WRITE, 8'h2a, BANK_USER, 32'h0bad_0002, 8'h00);
        send(CMD_GLOBAL_RESTORE, 8'h2a, BANK_USER, 32'h0, 8'h00);
        send(CMD_GLOBAL_READ, 8'h2a, BANK_USER, 32'h0, 8'h00);
        chk("restored", vl, 32'hcafe_0001);
        r = nv.n_rd;
        send(CMD_AXIS_RESTORE, 8'h06, BANK_SETTINGS, 32'h5555_aaaa, 8'h00);
        chk("axis status", 32'(st), 32'(STATUS_OK));
        chk("axis reads", nv.n_rd - r, 1);
        chk("axis addr", 32'(nv.addr_r), 32'h006);
        send(CMD_GLOBAL_STORE, 8'h2a, BANK_SETTINGS, 32'h0, 8'h00);
        chk("store bank", 32'(st), 32'(STATUS_BAD_TYPE));
        $display("test store done");
    endtask

    // Cuts a hang short.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fail_count++;
            summarize();
        end
    end

    // Reset, then the scenarios in order.
    initial
    begin
        repeat (8) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_boot();
        t_write();
        t_store();
        summarize();
    end
endmodule // param_store_cmd_tb
